// ---- hdl/flash_host.sv ----
/*
  Host controller for a serial configuration flash: takes one command at
  a time on a user port, frames it on chip select, makes the serial clock
  by dividing CLK, inserts write enable and busy polling as needed.
  Assumes the flash answers on the link lines; the bench resolves pins.
*/
`timescale 1ns/1ps
`include "flash_host_consts.svh"
module flash_host #(
  parameter int HALF_DIV = 4
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [7:0] CMD_OPCODE,
  input wire logic [31:0] CMD_ADDR,
  input wire logic [8:0] CMD_LEN,
  input wire logic [3:0] CMD_DUMMY,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_VALID,
  output logic WR_READY,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic DONE,
  output logic REFUSED,
  output logic WIDE_MODE,
  output logic [7:0] STATUS,
  output logic SERIAL_CLOCK,
  output logic SELECT_N,
  output logic [3:0] LINE_OUT,
  output logic [3:0] LINE_OE_N,
  input wire logic [3:0] LINE_IN
);
  flash_host_pkg::state_type state_r;
  flash_host_pkg::kind_type kind_r;
  logic [7:0] op_r, frame_op;
  logic [31:0] addr_r;
  logic [8:0] len_r;
  logic [3:0] dummy_r, gap_r;
  logic launch_r, refuse_nxt, wide_r, frame_end;
  logic [7:0] status_r;
  logic sck_r, cs_n_r, cur_rd_r, cur_wr_r;
  logic [7:0] div_r, tx_r, rx_r, rd_data_r;
  logic [3:0] bitcnt_r;
  logic [2:0] width_r, addr_left_r;
  logic [3:0] dummy_left_r;
  logic [8:0] data_left_r;
  logic [31:0] addr_sh_r;
  logic rd_valid_r, tick, boundary, stall, done_r, refused_r;
  logic [3:0] s1_r, s2_r, s3_r, in_r, in_ok;

  function automatic logic op_needs_wel(input logic [7:0] op);
    return op == `OPC_PAGE_WR || op == `OPC_DUAL_WR || op == `OPC_QUAD_WR ||
      op == `OPC_WR_STATUS || op == `OPC_BULK_ERASE || op == `OPC_SECTOR_ERASE ||
      op == `OPC_WIDE_ENTER || op == `OPC_WIDE_EXIT;
  endfunction
  function automatic logic op_prog(input logic [7:0] op);
    return op_needs_wel(op) && op != `OPC_WIDE_ENTER && op != `OPC_WIDE_EXIT;
  endfunction
  function automatic logic op_addr(input logic [7:0] op);
    return op == `OPC_READ || op == `OPC_FAST_READ || op == `OPC_DUAL_READ ||
      op == `OPC_QUAD_READ || op == `OPC_PAGE_WR || op == `OPC_DUAL_WR ||
      op == `OPC_QUAD_WR || op == `OPC_SECTOR_ERASE;
  endfunction
  function automatic logic op_read(input logic [7:0] op);
    return op == `OPC_RD_STATUS || op == `OPC_READ || op == `OPC_RD_ID ||
      op == `OPC_RD_ID_ALT || op == `OPC_FAST_READ || op == `OPC_DUAL_READ ||
      op == `OPC_QUAD_READ;
  endfunction
  function automatic logic op_wdata(input logic [7:0] op);
    return op == `OPC_PAGE_WR || op == `OPC_DUAL_WR || op == `OPC_QUAD_WR ||
      op == `OPC_WR_STATUS;
  endfunction
  function automatic logic op_known(input logic [7:0] op);
    return op_read(op) || op_needs_wel(op) || op == `OPC_WREN || op == `OPC_WRDI;
  endfunction
  function automatic logic [3:0] op_dummy(input logic [7:0] op);
    case (op)
      `OPC_FAST_READ: return `DUMMY_FAST;
      `OPC_DUAL_READ: return `DUMMY_DUAL;
      `OPC_QUAD_READ: return `DUMMY_QUAD;
      default: return 4'h0;
    endcase
  endfunction
  function automatic logic [2:0] op_width(input logic [7:0] op);
    if (op == `OPC_DUAL_READ || op == `OPC_DUAL_WR)
      return 3'h2;
    else if (op == `OPC_QUAD_READ || op == `OPC_QUAD_WR)
      return 3'h4;
    else
      return 3'h1;
  endfunction
  // 32-sector protection map; only the mirrored status is known here
  function automatic logic prot_hit(input logic [4:0] sec, input logic tb,
                                    input logic [2:0] bp);
    logic [5:0] n;
    n = (bp >= 3'h6) ? `SECTOR_COUNT : ((bp == 3'h0) ? 6'h0 : 6'h1 << (bp - 3'h1));
    if (tb)
      return {1'b0, sec} < n;
    else
      return {1'b0, sec} >= `SECTOR_COUNT - n;
  endfunction

  // request checks before anything reaches the link
  always_comb
  begin
    refuse_nxt = 1'b0;
    if (!op_known(CMD_OPCODE))
      refuse_nxt = 1'b1;
    else if (op_wdata(CMD_OPCODE) && (CMD_LEN == 9'h0 || CMD_LEN > `PAGE_MAX))
      refuse_nxt = 1'b1;
    else if (op_read(CMD_OPCODE) && CMD_LEN == 9'h0)
      refuse_nxt = 1'b1;
    else if (CMD_OPCODE == `OPC_BULK_ERASE && status_r[`ST_BP_MSB:`ST_BP_LSB] != 3'h0)
      refuse_nxt = 1'b1;
    else if ((op_wdata(CMD_OPCODE) && CMD_OPCODE != `OPC_WR_STATUS ||
              CMD_OPCODE == `OPC_SECTOR_ERASE) &&
             prot_hit(CMD_ADDR[`SECTOR_LSB+4:`SECTOR_LSB], status_r[`ST_BIT_TB],
                      status_r[`ST_BP_MSB:`ST_BP_LSB]))
      refuse_nxt = 1'b1;
  end

  // command sequencing: write enable, main frame, busy polling
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_r <= flash_host_pkg::ST_IDLE;
      kind_r <= flash_host_pkg::FK_MAIN;
      op_r <= 8'h00;
      addr_r <= 32'h0;
      len_r <= 9'h0;
      dummy_r <= 4'h0;
      gap_r <= 4'h0;
      launch_r <= 1'b0;
      done_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      launch_r <= 1'b0;
      done_r <= 1'b0;
      case (state_r)
        flash_host_pkg::ST_IDLE:
          if (CMD_VALID)
          begin
            op_r <= CMD_OPCODE;
            addr_r <= CMD_ADDR;
            len_r <= CMD_LEN;
            dummy_r <= (CMD_DUMMY != 4'h0) ? CMD_DUMMY : op_dummy(CMD_OPCODE);
            refused_r <= refuse_nxt;
            if (refuse_nxt)
              state_r <= flash_host_pkg::ST_DONE;
            else
            begin
              // latch is set just before use, so it is never 0 at use
              kind_r <= op_needs_wel(CMD_OPCODE) ? flash_host_pkg::FK_WREN
                : flash_host_pkg::FK_MAIN;
              launch_r <= 1'b1;
              state_r <= flash_host_pkg::ST_FRAME;
            end
          end
        flash_host_pkg::ST_FRAME:
          if (frame_end)
          begin
            gap_r <= `GAP_CYCLES;
            state_r <= flash_host_pkg::ST_GAP;
          end
        flash_host_pkg::ST_GAP:
          if (gap_r != 4'h0)
            gap_r <= gap_r - 4'h1;
          else if (kind_r == flash_host_pkg::FK_WREN)
          begin
            kind_r <= flash_host_pkg::FK_MAIN;
            launch_r <= 1'b1;
            state_r <= flash_host_pkg::ST_FRAME;
          end
          else if (kind_r == flash_host_pkg::FK_MAIN && op_prog(op_r) ||
                   kind_r == flash_host_pkg::FK_POLL && status_r[`ST_BIT_WIP])
          begin
            // wait out program or erase before releasing the user port
            kind_r <= flash_host_pkg::FK_POLL;
            launch_r <= 1'b1;
            state_r <= flash_host_pkg::ST_FRAME;
          end
          else
            state_r <= flash_host_pkg::ST_DONE;
        default:
        begin
          done_r <= 1'b1;
          state_r <= flash_host_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign frame_op = (kind_r == flash_host_pkg::FK_WREN) ? `OPC_WREN
    : (kind_r == flash_host_pkg::FK_POLL) ? `OPC_RD_STATUS : op_r;

  // addressing mode and status mirror
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wide_r <= 1'b0;
      status_r <= 8'h00;
    end
    else
    begin
      if (frame_end && kind_r == flash_host_pkg::FK_MAIN && op_r == `OPC_WIDE_ENTER)
        wide_r <= 1'b1;
      else if (frame_end && kind_r == flash_host_pkg::FK_MAIN && op_r == `OPC_WIDE_EXIT)
        wide_r <= 1'b0;
      if (boundary && cur_rd_r && frame_op == `OPC_RD_STATUS)
        status_r <= rx_r;
    end
  end

  // three-stage input sampling, taken when the last two agree
  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    always_ff @(posedge CLK or negedge RSTN)
    begin
      if (!RSTN)
      begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
        in_r[i] <= 1'b0;
      end
      else
      begin
        s1_r[i] <= LINE_IN[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i])
          in_r[i] <= s3_r[i];
      end
    end
  end

  // level the filter settles on at this edge; in_r would be one edge late
  assign in_ok = (s2_r & s3_r) | (in_r & (s2_r ^ s3_r));

  // clock holds high while write data is late, so the flash just waits
  assign boundary = sck_r && bitcnt_r == 4'h0 && div_r == 8'(HALF_DIV - 1) && !stall;
  assign stall = sck_r && bitcnt_r == 4'h0 && addr_left_r == 3'h0 &&
    dummy_left_r == 4'h0 && data_left_r != 9'h0 && op_wdata(frame_op) && !WR_VALID;
  assign tick = !cs_n_r && div_r == 8'(HALF_DIV - 1) && !stall;
  assign frame_end = boundary && addr_left_r == 3'h0 && dummy_left_r == 4'h0 &&
    data_left_r == 9'h0;
  assign WR_READY = boundary && addr_left_r == 3'h0 && dummy_left_r == 4'h0 &&
    data_left_r != 9'h0 && op_wdata(frame_op);

  // bit engine: change on falling clock, flash samples on rising
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      div_r <= 8'h00;
      bitcnt_r <= 4'h0;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      width_r <= 3'h1;
      cur_rd_r <= 1'b0;
      cur_wr_r <= 1'b0;
      addr_left_r <= 3'h0;
      dummy_left_r <= 4'h0;
      data_left_r <= 9'h0;
      addr_sh_r <= 32'h0;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= 1'b0;
      if (launch_r)
      begin
        cs_n_r <= 1'b0;
        sck_r <= 1'b0;
        div_r <= 8'h00;
        tx_r <= frame_op;
        bitcnt_r <= `BITS_PER_BYTE;
        width_r <= 3'h1;
        cur_rd_r <= 1'b0;
        cur_wr_r <= 1'b1;
        addr_left_r <= !op_addr(frame_op) ? 3'h0
          : wide_r ? `ADDR_BYTES_WIDE : `ADDR_BYTES_NARROW;
        addr_sh_r <= wide_r ? addr_r : {addr_r[23:0], 8'h00};
        dummy_left_r <= (kind_r == flash_host_pkg::FK_MAIN) ? dummy_r : 4'h0;
        data_left_r <= (kind_r == flash_host_pkg::FK_POLL) ? 9'h1
          : (kind_r == flash_host_pkg::FK_WREN) ? 9'h0
          : (op_read(frame_op) || op_wdata(frame_op)) ? len_r : 9'h0;
      end
      else if (tick)
      begin
        div_r <= 8'h00;
        sck_r <= !sck_r;
        if (!sck_r)
        begin
          bitcnt_r <= bitcnt_r - {1'b0, width_r};
          case (width_r)
            3'h4: rx_r <= {rx_r[3:0], in_ok};
            3'h2: rx_r <= {rx_r[5:0], in_ok[1:0]};
            default: rx_r <= {rx_r[6:0], in_ok[1]};
          endcase
        end
        else if (bitcnt_r != 4'h0)
          tx_r <= tx_r << width_r;
        else
        begin
          if (cur_rd_r)
          begin
            rd_data_r <= rx_r;
            rd_valid_r <= kind_r == flash_host_pkg::FK_MAIN;
          end
          if (addr_left_r != 3'h0)
          begin
            tx_r <= addr_sh_r[31:24];
            addr_sh_r <= addr_sh_r << 8;
            addr_left_r <= addr_left_r - 3'h1;
            bitcnt_r <= `BITS_PER_BYTE;
          end
          else if (dummy_left_r != 4'h0)
          begin
            tx_r <= 8'h00;
            dummy_left_r <= dummy_left_r - 4'h1;
            bitcnt_r <= `BITS_PER_BYTE;
          end
          else if (data_left_r != 9'h0)
          begin
            // read data keeps coming until select rises after len bytes
            tx_r <= op_wdata(frame_op) ? WR_DATA : 8'h00;
            data_left_r <= data_left_r - 9'h1;
            width_r <= op_width(frame_op);
            cur_rd_r <= op_read(frame_op);
            cur_wr_r <= !op_read(frame_op);
            bitcnt_r <= `BITS_PER_BYTE;
          end
          else
          begin
            cs_n_r <= 1'b1;
            cur_rd_r <= 1'b0;
            cur_wr_r <= 1'b0;
          end
        end
      end
      else if (!cs_n_r && !stall)
        div_r <= div_r + 8'h01; // held in a stall so the high half finishes its remaining count once write data arrives
    end
  end

  always_comb
  begin
    LINE_OUT = 4'h0;
    LINE_OE_N = 4'hF;
    if (!cs_n_r && cur_wr_r)
    begin
      case (width_r)
        3'h4:
        begin
          LINE_OUT = tx_r[7:4];
          LINE_OE_N = 4'h0;
        end
        3'h2:
        begin
          LINE_OUT = {2'b00, tx_r[7:6]};
          LINE_OE_N = 4'hC;
        end
        default:
        begin
          LINE_OUT = {3'b000, tx_r[7]};
          LINE_OE_N = 4'hE;
        end
      endcase
    end
  end

  assign CMD_READY = state_r == flash_host_pkg::ST_IDLE;
  assign SERIAL_CLOCK = sck_r;
  assign SELECT_N = cs_n_r;
  assign RD_DATA = rd_data_r;
  assign RD_VALID = rd_valid_r;
  assign DONE = done_r;
  assign REFUSED = refused_r;
  assign WIDE_MODE = wide_r;
  assign STATUS = status_r;

  // checking helpers
  logic [2:0] pulse_mod_r;
  logic wren_seen_r;
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      pulse_mod_r <= 3'h0;
      wren_seen_r <= 1'b0;
    end
    else
    begin
      if (launch_r)
        pulse_mod_r <= 3'h0;
      else if (tick && !sck_r)
        pulse_mod_r <= pulse_mod_r + 3'h1;
      if (frame_end && kind_r == flash_host_pkg::FK_WREN)
        wren_seen_r <= 1'b1;
      else if (launch_r && kind_r == flash_host_pkg::FK_MAIN)
        wren_seen_r <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_byte_boundary: assert property ($rose(cs_n_r) && !op_read(frame_op) |->
    pulse_mod_r == 3'h0)
    else $error("select rose off a byte boundary");
  a_msb_first: assert property (launch_r |=> LINE_OUT[0] == $past(frame_op[7]))
    else $error("opcode msb not first on line zero");
  a_wren_first: assert property (launch_r && kind_r == flash_host_pkg::FK_MAIN &&
    op_needs_wel(op_r) |-> wren_seen_r)
    else $error("write enable missing before command");
  a_clock_framed: assert property (sck_r |-> !cs_n_r)
    else $error("serial clock high outside a frame");
  a_addr_count: assert property (launch_r && op_addr(frame_op) |=>
    addr_left_r == (wide_r ? 3'h4 : 3'h3))
    else $error("wrong address byte count");
  a_quad_dummy: assert property (launch_r && kind_r == flash_host_pkg::FK_MAIN &&
    op_r == `OPC_QUAD_READ && $past(CMD_DUMMY == 4'h0 && CMD_VALID) |=>
    dummy_left_r == 4'hA)
    else $error("quad read dummy count wrong");
  a_wide_enter: assert property (frame_end && kind_r == flash_host_pkg::FK_MAIN &&
    op_r == `OPC_WIDE_ENTER |=> wide_r ##1 wide_r)
    else $error("wide mode not entered");
  a_bulk_refuse: assert property (CMD_READY && CMD_VALID && CMD_OPCODE == `OPC_BULK_ERASE
    && status_r[`ST_BP_MSB:`ST_BP_LSB] != 3'h0 |-> ##[1:3] DONE && REFUSED)
    else $error("bulk erase not refused");
  a_busy_hold: assert property (launch_r && kind_r == flash_host_pkg::FK_MAIN &&
    !op_needs_wel(op_r) |-> !status_r[`ST_BIT_WIP])
    else $error("access launched while busy");
  c_wide_enter: cover property (frame_end && op_r == `OPC_WIDE_ENTER);
  c_quad_read: cover property (RD_VALID && op_r == `OPC_QUAD_READ);
  c_page_done: cover property (DONE && !REFUSED && op_r == `OPC_PAGE_WR);
  c_refused: cover property (DONE && REFUSED);
  c_write_stall: cover property (stall);
endmodule

// ---- hdl/flash_host_consts.svh ----
/*
  Constants for the serial flash host controller: opcodes, byte counts,
  status bit positions and link pacing. Assumes the flash decodes
  8-bit opcodes shifted in most significant bit first.
*/
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH
`define OPC_RD_STATUS 8'h05
`define OPC_READ 8'h03
`define OPC_RD_ID 8'h9E
`define OPC_RD_ID_ALT 8'h9F
`define OPC_FAST_READ 8'h0B
`define OPC_DUAL_READ 8'hBB
`define OPC_QUAD_READ 8'hEB
`define OPC_WREN 8'h06
`define OPC_WRDI 8'h04
`define OPC_WR_STATUS 8'h01
`define OPC_PAGE_WR 8'h02
`define OPC_DUAL_WR 8'hD2
`define OPC_QUAD_WR 8'h12
`define OPC_BULK_ERASE 8'hC7
`define OPC_SECTOR_ERASE 8'hD8
`define OPC_WIDE_ENTER 8'hB7
`define OPC_WIDE_EXIT 8'hE9
`define DUMMY_FAST 4'h8
`define DUMMY_DUAL 4'h8
`define DUMMY_QUAD 4'hA
`define ADDR_BYTES_NARROW 3'h3
`define ADDR_BYTES_WIDE 3'h4
`define PAGE_MAX 9'h100
`define BITS_PER_BYTE 4'h8
`define ST_BIT_WIP 0
`define ST_BIT_WEL 1
`define ST_BP_LSB 2
`define ST_BP_MSB 4
`define ST_BIT_TB 5
`define SECTOR_LSB 16
`define SECTOR_COUNT 6'h20
`define GAP_CYCLES 4'h4
`endif

// ---- hdl/flash_host_pkg.sv ----
/*
  Types for the serial flash host controller.
  Assumes flash_host_consts.svh supplies the numeric constants.
*/
package flash_host_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_GAP, ST_DONE} state_type;
  typedef enum logic [1:0] {FK_WREN, FK_MAIN, FK_POLL} kind_type;
endpackage

// ---- verif/flash_model.sv ----
/*
  Behavioural serial flash facing the host controller.
  Assumes mode-0 framing: bits in on rising clock, answers on line one.
*/
`timescale 1ns/1ps
module flash_model #(
  parameter int BUSY_POLLS = 3
) (
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic din,
  output logic dout
);
  logic [7:0] sr = 8'h00;
  logic [7:0] op = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic [7:0] obyte;
  logic [31:0] addr = 32'h0;
  logic wel = 1'b0;
  logic wide = 1'b0;
  logic drive = 1'b0;
  logic last = 1'b0;
  int edges = 0, busy = 0, len_main = 0, frames = 0, bad = 0, idx = 0;
  int na;
  assign na = wide ? 4 : 3;
  // released line shows the inverse, not a stale copy
  assign dout = drive ? last : ~last;
  always @(negedge sel_n)
  begin
    edges = 0;
    addr = 32'h0;
    frames++;
  end
  always @(posedge sclk)
  begin
    if (!sel_n)
    begin
      sh = {sh[6:0], din};
      edges++;
      idx = edges / 8 - 1;
      if (edges % 8 == 0)
      begin
        if (idx == 0) op = sh;
        if (idx == 0 && busy > 0 && sh != 8'h05) bad++;
        if (idx > 0 && idx <= na) addr = {addr[23:0], sh};
        if (idx > 0 && op != 8'h05) wdat = sh;
      end
    end
  end
  always @(posedge sel_n)
  begin
    if (op != 8'h05) len_main = edges;
    if (edges % 8 == 0)
      case (op)
        8'h06: wel = 1'b1;
        8'h04: wel = 1'b0;
        8'h05: if (busy > 0) busy--;
        8'hB7, 8'hE9: if (wel) wide = (op == 8'hB7);
        8'h01, 8'h02, 8'hD2, 8'h12, 8'hD8, 8'hC7:
          if (wel && !(op == 8'hC7 && sr[4:2] != 3'h0))
          begin
            if (op == 8'h01) sr = wdat & 8'h3C;
            busy = BUSY_POLLS;
            wel = 1'b0;
          end
        default: ;
      endcase
    drive = 1'b0;
  end
  always @(negedge sclk)
  begin
    if (!sel_n && edges >= 8)
    begin
      obyte = (op == 8'h05) ? {sr[7:2], wel, busy > 0} : addr[7:0] + 8'(idx - na);
      drive = (op == 8'h05) || (op == 8'h03 && edges >= 8 * (1 + na));
      if (drive) last = obyte[7 - edges % 8];
    end
  end
endmodule

// ---- verif/tb.sv ----
/*
  Self-checking bench for flash_host against the behavioural flash.
  Assumes HALF_DIV of 4 and the flash answering on line one.
*/
`timescale 1ns/1ps
module tb;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic CMD_VALID = 1'b0;
  logic [7:0] CMD_OPCODE = 8'h00;
  logic [31:0] CMD_ADDR = 32'h0;
  logic [8:0] CMD_LEN = 9'h000;
  logic [3:0] CMD_DUMMY = 4'h0;
  logic [7:0] WR_DATA = 8'h00;
  logic WR_VALID = 1'b1;
  logic CMD_READY, WR_READY, RD_VALID, DONE, REFUSED, WIDE_MODE, SERIAL_CLOCK, SELECT_N;
  logic fm_dout;
  logic [7:0] RD_DATA, STATUS;
  logic [7:0] wr_base = 8'h00;
  logic [3:0] LINE_OUT, LINE_OE_N, LINE_IN;
  logic [7:0] rd_q [0:15];
  int rd_n = 0, wr_n = 0, cyc = 0, num_errors = 0, check_count = 0, hold_n = 0;
  flash_host #(.HALF_DIV(4)) dut (.CLK(CLK), .RSTN(RSTN), .CMD_VALID(CMD_VALID),
    .CMD_READY(CMD_READY), .CMD_OPCODE(CMD_OPCODE), .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN),
    .CMD_DUMMY(CMD_DUMMY), .WR_DATA(WR_DATA), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
    .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .DONE(DONE), .REFUSED(REFUSED),
    .WIDE_MODE(WIDE_MODE), .STATUS(STATUS), .SERIAL_CLOCK(SERIAL_CLOCK),
    .SELECT_N(SELECT_N), .LINE_OUT(LINE_OUT), .LINE_OE_N(LINE_OE_N), .LINE_IN(LINE_IN));
  flash_model fm (.sclk(SERIAL_CLOCK), .sel_n(SELECT_N), .din(LINE_IN[0]), .dout(fm_dout));
  // line one carries the flash unless the host enables it
  assign LINE_IN = {LINE_OUT[3:2], LINE_OE_N[1] ? fm_dout : LINE_OUT[1], LINE_OUT[0]};
  initial forever #12.5 CLK = ~CLK;
  // sampled mid-cycle so pulses are seen settled
  always @(negedge CLK)
  begin
    if (RD_VALID === 1'b1 && rd_n < 16) rd_q[rd_n] = RD_DATA;
    if (RD_VALID === 1'b1) rd_n++;
    if (WR_READY === 1'b1) wr_n++;
    if (WR_READY === 1'b1) hold_n = 20;
  end
  always @(posedge CLK)
  begin
    WR_DATA <= wr_base + 8'(wr_n);
    // data goes missing after each byte, so quad writes must stall the clock
    WR_VALID <= hold_n < 2;
    if (hold_n > 0) hold_n--;
    cyc++;
    if (cyc == 90000)
    begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [31:0] a, input logic [8:0] n,
    input logic [3:0] d, input logic exp_ref);
    int t;
    t = 0;
    CMD_OPCODE <= op;
    CMD_ADDR <= a;
    CMD_LEN <= n;
    CMD_DUMMY <= d;
    CMD_VALID <= 1'b1;
    @(negedge CLK);
    rd_n = 0;
    wr_n = 0;
    @(posedge CLK);
    CMD_VALID <= 1'b0;
    @(negedge CLK);
    while (DONE !== 1'b1 && t < 30000)
    begin
      @(negedge CLK);
      t++;
    end
    chk("done_refused", {30'h0, 1'b1, exp_ref}, {30'h0, DONE, REFUSED});
    @(posedge CLK);
  endtask
  task automatic t_latch();
    cmd(8'h06, 32'h0, 9'h000, 4'h0, 1'b0);
    cmd(8'h05, 32'h0, 9'h002, 4'h0, 1'b0);
    chk("wel_set", 32'h0202, {16'h0, rd_q[0], rd_q[1]});
    chk("rd_count", 32'h2, 32'(rd_n));
    cmd(8'h04, 32'h0, 9'h000, 4'h0, 1'b0);
    cmd(8'h05, 32'h0, 9'h001, 4'h0, 1'b0);
    chk("wel_clear", 32'h00, {24'h0, STATUS});
  endtask
  task automatic t_read();
    cmd(8'h03, 32'h0001_2345, 9'h003, 4'h0, 1'b0);
    chk("rd_bytes", 32'h454647, {8'h0, rd_q[0], rd_q[1], rd_q[2]});
    chk("rd_addr", 32'h0001_2345, fm.addr);
    chk("rd_edges", 32'd56, 32'(fm.len_main));
  endtask
  task automatic t_dummy();
    logic [7:0] ops [0:3] = '{8'h0B, 8'hBB, 8'hEB, 8'hEB};
    logic [3:0] dm [0:3] = '{4'h0, 4'h0, 4'h0, 4'h3};
    // opcode, 3 address, dummy bytes, one data byte over 1, 2 or 4 lines
    int exp_e [0:3] = '{104, 100, 114, 58};
    for (int i = 0; i < 4; i++)
    begin
      cmd(ops[i], 32'h0000_0010, 9'h001, dm[i], 1'b0);
      chk("dummy_edges", 32'(exp_e[i]), 32'(fm.len_main));
    end
  endtask
  task automatic t_write();
    int f;
    f = fm.frames;
    wr_base = 8'h30;
    cmd(8'h02, 32'h0000_0100, 9'h002, 4'h0, 1'b0);
    chk("wr_last", 32'h31, {24'h0, fm.wdat});
    chk("wr_edges", 32'd48, 32'(fm.len_main));
    // enable, program, then four polls as the busy flag drains
    chk("wr_frames", 32'd6, 32'(fm.frames - f));
    chk("wr_status", 32'h00, {24'h0, STATUS});
    cmd(8'hD2, 32'h0000_0200, 9'h002, 4'h0, 1'b0);
    chk("dual_edges", 32'd40, 32'(fm.len_main));
    cmd(8'h12, 32'h0000_0300, 9'h004, 4'h0, 1'b0);
    chk("quad_edges", 32'd40, 32'(fm.len_main));
  endtask
  task automatic t_protect();
    logic [7:0] p_sr [0:6] = '{8'h1C, 8'h1C, 8'h04, 8'h04, 8'h24, 8'h24, 8'h00};
    logic [7:0] p_op [0:6] = '{8'hC7, 8'hD8, 8'hD8, 8'hD8, 8'hD8, 8'hD8, 8'hC7};
    logic [31:0] p_ad [0:6] = '{0, 0, 32'h001F_0000, 0, 0, 32'h001F_0000, 0};
    logic p_rf [0:6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    for (int i = 0; i < 7; i++)
    begin
      if (i == 0 || p_sr[i] != p_sr[i - 1])
      begin
        wr_base = p_sr[i];
        cmd(8'h01, 32'h0, 9'h001, 4'h0, 1'b0);
        chk("sr_mirror", {24'h0, p_sr[i]}, {24'h0, STATUS});
      end
      cmd(p_op[i], p_ad[i], 9'h000, 4'h0, p_rf[i]);
    end
  endtask
  task automatic t_wide();
    cmd(8'hB7, 32'h0, 9'h000, 4'h0, 1'b0);
    chk("wide_on", 32'h3, {30'h0, WIDE_MODE, fm.wide});
    chk("wide_edges", 32'd8, 32'(fm.len_main));
    cmd(8'h03, 32'h0123_4567, 9'h001, 4'h0, 1'b0);
    chk("wide_addr", 32'h0123_4567, fm.addr);
    chk("wide_byte", 32'h67, {24'h0, rd_q[0]});
    cmd(8'hE9, 32'h0, 9'h000, 4'h0, 1'b0);
    chk("wide_off", 32'h0, {30'h0, WIDE_MODE, fm.wide});
  endtask
  task automatic t_refuse();
    logic [7:0] ops [0:3] = '{8'h77, 8'h02, 8'h02, 8'h03};
    logic [8:0] ln [0:3] = '{9'h001, 9'h000, 9'h101, 9'h000};
    int f;
    for (int i = 0; i < 4; i++)
    begin
      f = fm.frames;
      cmd(ops[i], 32'h0, ln[i], 4'h0, 1'b1);
      chk("no_frame", 32'(f), 32'(fm.frames));
    end
  endtask
  initial
  begin
    repeat (4) @(posedge CLK);
    @(negedge CLK);
    chk("reset_idle", 32'hDE00, {16'h0, CMD_READY, SELECT_N, SERIAL_CLOCK, LINE_OE_N,
      STATUS, WIDE_MODE});
    @(posedge CLK);
    RSTN <= 1'b1;
    t_latch();
    t_read();
    t_dummy();
    t_write();
    t_protect();
    t_wide();
    t_refuse();
    chk("busy_access", 32'h0, 32'(fm.bad));
    final_report();
  end
endmodule
